// >>> hdl/amp_serial_pkg.sv
// Shared constants for the amplifier mode and volume serial port and its host.
`default_nettype none

package amp_serial_pkg;

  // ---------------------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int MODE_LSB  = 0;
  localparam int MODE_W    = 3;
  localparam int VOL_LSB   = 3;
  localparam int VOL_W     = 5;
  localparam int CNT_W     = 4;

  // Reset values of the latched settings.
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam logic [VOL_W-1:0]  VOL_RESET  = 5'h00;

  // Output mode codes.
  localparam logic [MODE_W-1:0] MODE_ALL_OFF       = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SPK_PHONE     = 3'h1;
  localparam logic [MODE_W-1:0] MODE_HP_PHONE      = 3'h2;
  localparam logic [MODE_W-1:0] MODE_SPK_SUM       = 3'h3;
  localparam logic [MODE_W-1:0] MODE_HP_CHAN       = 3'h4;
  localparam logic [MODE_W-1:0] MODE_SPK_SUM_PHONE = 3'h5;
  localparam logic [MODE_W-1:0] MODE_HP_CHAN_PHONE = 3'h6;
  localparam logic [MODE_W-1:0] MODE_BOTH          = 3'h7;

  // Gain in tenths of a decibel: lowest code and step per code.
  localparam int GAIN_W            = 10;
  localparam int GAIN_MIN_TENTHS   = -405;
  localparam int GAIN_STEP_TENTHS  = 15;

  // ---------------------------------------------------------------------------
  // Timing, with the local clock period in picoseconds
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int T_ABORT_LOW_NS  = 10;
  localparam int T_CLK_HALF_NS   = 50;
  localparam int T_EN_SETUP_NS   = 20;
  localparam int T_EN_HOLD_NS    = 20;
  localparam int T_EN_LOW_NS     = 30;
  // Longest time rounds down, least times round up.
  localparam int ABORT_LOW_CYC   = (T_ABORT_LOW_NS * 1000) / CLK_PERIOD_PS;
  localparam int CLK_HALF_CYC    = (T_CLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EN_SETUP_CYC    = (T_EN_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EN_HOLD_CYC     = (T_EN_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EN_LOW_CYC      = (T_EN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Host register map over AXI4-Lite
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CMD_OFFSET     = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0004;
  localparam int          CMD_WORD_LSB   = 0;
  localparam int          CMD_LEN_LSB    = 8;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_CNT_LSB   = 8;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : amp_serial_pkg

`default_nettype wire

// >>> hdl/amp_serial_if.sv
// Three-wire serial link between the host and the amplifier port.
`default_nettype none

interface amp_serial_if;
  logic sclk;
  logic sdata;
  logic serial_enable_high;

  modport host (output sclk, output sdata, output serial_enable_high);
  modport device (input sclk, input sdata, input serial_enable_high);
endinterface : amp_serial_if

`default_nettype wire

// >>> hdl/amp_serial_device.sv
// Amplifier serial mode and volume port: shifts, checks and latches one word.
//
// Functional notes
// - Word: bits 0-2 mode, bits 3-7 volume.
// - Host sends least significant bit first.
// - Sample data on rising clock while enabled.
// - Enable falling edge completes and latches word.
// - Latch only after full eight bits.
// - Ignore clock and data after eighth edge.
// - Extra pulses: keep first eight bits.
// - Enable low over 10ns early aborts.
// - Modes 0-3 select documented output routing.
// - Modes 4-7 select documented output routing.
// - Power-up in mode 0, all outputs off.
// - Volume code maps linearly, 1.5 dB steps.
// - Host enables only while sending word; the host also raises enable for a len_reg of 0, with no bits.
// - Enable spans first to eighth rising edge; the host gives len_reg rising edges, from 0 to 15.
// - Clock and enable edges never coincide.
`default_nettype none

module amp_serial_device
  import amp_serial_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  amp_serial_if.device                           link,
  output logic [amp_serial_pkg::MODE_W-1:0]      mode,
  output logic [amp_serial_pkg::VOL_W-1:0]       volume,
  output logic signed [amp_serial_pkg::GAIN_W-1:0] gain_tenth_db,
  output logic                                   loudspeaker_output_off,
  output logic                                   right_headphone_output_off,
  output logic                                   left_headphone_output_off,
  output logic                                   spk_phone_6db,
  output logic                                   spk_gained_sum,
  output logic                                   hp_gained_channels,
  output logic                                   hp_phone,
  output logic                                   word_latched,
  output logic                                   transfer_aborted
);

  import amp_serial_pkg::*;

  // ---------------------------------------------------------------------------
  // Link clock domain: shift register and bit counter
  // ---------------------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_reg;
  logic [CNT_W-1:0]     bit_cnt_reg;
  logic                 full_reg;
  logic                 last_bit;

  assign last_bit = (bit_cnt_reg == CNT_W'(WORD_BITS - 1));

  // Enable low clears the frame; the register shifts right so the first bit
  // ends in bit 0. Once full, further edges change nothing.
  always_ff @(posedge link.sclk or negedge link.serial_enable_high) begin
    if (!link.serial_enable_high) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      full_reg    <= 1'b0;
    end else if (!full_reg) begin
      shift_reg   <= {link.sdata, shift_reg[WORD_BITS-1:1]};
      bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
      full_reg    <= last_bit;
    end
  end

  // ---------------------------------------------------------------------------
  // Local clock domain: synchronisers for enable and word-complete level
  // ---------------------------------------------------------------------------
  logic [2:0] en_sync_reg;
  logic [2:0] full_sync_reg;
  logic       en_level_reg;
  logic       full_level_reg;
  logic       en_agree;
  logic       full_agree;

  // A change counts once the second and third stages agree.
  assign en_agree   = (en_sync_reg[1] == en_sync_reg[2]);
  assign full_agree = (full_sync_reg[1] == full_sync_reg[2]);

  // Three-stage synchronisers and the filtered levels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_sync_reg    <= '0;
      full_sync_reg  <= '0;
      en_level_reg   <= 1'b0;
      full_level_reg <= 1'b0;
    end else begin
      en_sync_reg    <= {en_sync_reg[1:0], link.serial_enable_high};
      full_sync_reg  <= {full_sync_reg[1:0], full_reg};
      if (en_agree) begin
        en_level_reg <= en_sync_reg[2];
      end
      if (full_agree) begin
        full_level_reg <= full_sync_reg[2];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Frame tracking: capture, low-time filter, commit or abort
  // ---------------------------------------------------------------------------
  localparam int LOW_W = 4;
  localparam logic [LOW_W-1:0] ABORT_LOW_LIMIT = LOW_W'(ABORT_LOW_CYC);

  logic                 frame_active_reg;
  logic                 pending_reg;
  logic [WORD_BITS-1:0] pending_word_reg;
  logic [LOW_W-1:0]     low_cnt_reg;
  logic                 frame_end;
  logic                 capture;
  logic                 commit;
  logic                 abort;

  // The frame ends once enable has stayed low for the filter time.
  assign frame_end = frame_active_reg && !en_level_reg && (low_cnt_reg >= ABORT_LOW_LIMIT);
  // The word is stable while the full level stands and enable is still high.
  assign capture   = frame_active_reg && en_level_reg && full_level_reg && !pending_reg;
  assign commit    = frame_end && pending_reg;
  assign abort     = frame_end && !pending_reg;

  // Frame state, low-time counter and the captured word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_active_reg <= 1'b0;
      pending_reg      <= 1'b0;
      pending_word_reg <= '0;
      low_cnt_reg      <= '0;
    end else begin
      if (en_level_reg) begin
        frame_active_reg <= 1'b1;
        low_cnt_reg      <= '0;
      end else if (frame_end) begin
        frame_active_reg <= 1'b0;
        low_cnt_reg      <= '0;
      end else if (frame_active_reg) begin
        low_cnt_reg      <= low_cnt_reg + LOW_W'(1);
      end
      if (frame_end) begin
        pending_reg      <= 1'b0;
      end else if (capture) begin
        pending_reg      <= 1'b1;
        pending_word_reg <= shift_reg;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Latched settings and event pulses
  // ---------------------------------------------------------------------------
  logic [MODE_W-1:0] mode_reg;
  logic [VOL_W-1:0]  vol_reg;
  logic              latched_reg;
  logic              aborted_reg;

  // Settings change only on a commit; an abort leaves them as they were.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg    <= MODE_RESET;
      vol_reg     <= VOL_RESET;
      latched_reg <= 1'b0;
      aborted_reg <= 1'b0;
    end else begin
      latched_reg <= commit;
      aborted_reg <= abort;
      if (commit) begin
        mode_reg <= pending_word_reg[MODE_LSB +: MODE_W];
        vol_reg  <= pending_word_reg[VOL_LSB +: VOL_W];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Routing decode of the latched mode
  // ---------------------------------------------------------------------------
  logic spk_phone_next;
  logic spk_sum_next;
  logic hp_chan_next;
  logic hp_phone_next;
  logic spk_off_next;
  logic hp_off_next;
  logic signed [GAIN_W-1:0] gain_next;

  // Loudspeaker sources.
  assign spk_phone_next = (mode_reg == MODE_SPK_PHONE) || (mode_reg == MODE_SPK_SUM_PHONE)
                       || (mode_reg == MODE_BOTH);
  assign spk_sum_next   = (mode_reg == MODE_SPK_SUM) || (mode_reg == MODE_SPK_SUM_PHONE);
  // Headphone sources.
  assign hp_chan_next   = (mode_reg == MODE_HP_CHAN) || (mode_reg == MODE_HP_CHAN_PHONE)
                       || (mode_reg == MODE_BOTH);
  assign hp_phone_next  = (mode_reg == MODE_HP_PHONE) || (mode_reg == MODE_HP_CHAN_PHONE)
                       || (mode_reg == MODE_BOTH);
  // An output with no source is shut down.
  assign spk_off_next   = !(spk_phone_next || spk_sum_next);
  assign hp_off_next    = !(hp_chan_next || hp_phone_next);
  // Linear gain: lowest gain plus one step per code.
  assign gain_next      = GAIN_W'(GAIN_MIN_TENTHS)
                        + GAIN_W'(GAIN_STEP_TENTHS) * $signed({1'b0, vol_reg});

  // Registered routing outputs; all outputs off after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loudspeaker_output_off     <= 1'b1;
      right_headphone_output_off <= 1'b1;
      left_headphone_output_off  <= 1'b1;
      spk_phone_6db              <= 1'b0;
      spk_gained_sum             <= 1'b0;
      hp_gained_channels         <= 1'b0;
      hp_phone                   <= 1'b0;
      gain_tenth_db              <= GAIN_W'(GAIN_MIN_TENTHS);
    end else begin
      loudspeaker_output_off     <= spk_off_next;
      right_headphone_output_off <= hp_off_next;
      left_headphone_output_off  <= hp_off_next;
      spk_phone_6db              <= spk_phone_next;
      spk_gained_sum             <= spk_sum_next;
      hp_gained_channels         <= hp_chan_next;
      hp_phone                   <= hp_phone_next;
      gain_tenth_db              <= gain_next;
    end
  end

  assign mode             = mode_reg;
  assign volume           = vol_reg;
  assign word_latched     = latched_reg;
  assign transfer_aborted = aborted_reg;

endmodule : amp_serial_device

`default_nettype wire

// >>> hdl/amp_serial_host.sv
// Host end: AXI4-Lite command registers driving the three-wire serial link.
`default_nettype none

module amp_serial_host
  import amp_serial_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  amp_serial_if.host       link,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  import amp_serial_pkg::*;

  typedef enum logic [2:0] {IDLE, SETUP, CLK_HIGH, CLK_LOW, TAIL, GAP} host_state_e;

  host_state_e          state_reg;
  logic [7:0]           cnt_reg;
  logic [CNT_W-1:0]     len_reg;
  logic [CNT_W-1:0]     bit_idx_reg;
  logic [WORD_BITS-1:0] word_reg;
  logic [7:0]           sent_reg;
  logic                 sclk_reg;
  logic                 sdata_reg;
  logic                 en_reg;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic        do_write;
  logic        cmd_hit;
  logic        start;
  logic        busy;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [3:0]  strb_reg;
  logic [1:0]  wdata_strb_ok;

  assign busy          = (state_reg != IDLE);
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign cmd_hit       = (awaddr_reg[31:2] == CMD_OFFSET[31:2]);
  assign wdata_strb_ok = strb_reg[1:0];
  // A command is taken only when idle and the low byte lanes are written.
  assign start         = do_write && cmd_hit && !busy && (&wdata_strb_ok);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = (s_axi_araddr[31:2] == CMD_OFFSET[31:2])
                      || (s_axi_araddr[31:2] == STATUS_OFFSET[31:2]);
  assign rd_word       = (s_axi_araddr[31:2] == CMD_OFFSET[31:2])
                       ? {20'h00000, len_reg, word_reg}
                       : {16'h0000, sent_reg, 7'h00, busy};

  // Address and data are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      strb_reg     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        strb_reg   <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= start ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Serial sequencer: divider-made clock, enable framing
  // ---------------------------------------------------------------------------
  logic             cnt_done;
  logic             bit_now;
  logic [CNT_W-1:0] next_idx;
  logic             last_sent;

  assign cnt_done  = (cnt_reg == 8'h00);
  assign next_idx  = bit_idx_reg + CNT_W'(1);
  assign last_sent = (next_idx >= len_reg);
  // Bits past the word are sent as zero.
  assign bit_now   = (next_idx < CNT_W'(WORD_BITS)) ? word_reg[next_idx[2:0]] : 1'b0;

  // Enable rises, setup, len_reg clock periods, hold, enable falls, low gap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= IDLE;
      cnt_reg     <= '0;
      len_reg     <= '0;
      bit_idx_reg <= '0;
      word_reg    <= '0;
      sent_reg    <= '0;
      sclk_reg    <= 1'b0;
      sdata_reg   <= 1'b0;
      en_reg      <= 1'b0;
    end else begin
      if (!cnt_done) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      case (state_reg)
        IDLE: begin
          if (start) begin
            word_reg    <= wdata_reg[CMD_WORD_LSB +: WORD_BITS];
            len_reg     <= wdata_reg[CMD_LEN_LSB +: CNT_W];
            sdata_reg   <= wdata_reg[CMD_WORD_LSB];
            bit_idx_reg <= '0;
            en_reg      <= 1'b1;
            cnt_reg     <= 8'(EN_SETUP_CYC - 1);
            state_reg   <= SETUP;
          end
        end
        SETUP: begin
          if (cnt_done) begin
            sclk_reg  <= (len_reg != '0);
            cnt_reg   <= 8'(CLK_HALF_CYC - 1);
            state_reg <= (len_reg != '0) ? CLK_HIGH : TAIL;
          end
        end
        CLK_HIGH: begin
          if (cnt_done) begin
            sclk_reg    <= 1'b0;
            bit_idx_reg <= next_idx;
            sdata_reg   <= bit_now;
            cnt_reg     <= last_sent ? 8'(EN_HOLD_CYC - 1) : 8'(CLK_HALF_CYC - 1);
            state_reg   <= last_sent ? TAIL : CLK_LOW;
          end
        end
        CLK_LOW: begin
          if (cnt_done) begin
            sclk_reg  <= 1'b1;
            cnt_reg   <= 8'(CLK_HALF_CYC - 1);
            state_reg <= CLK_HIGH;
          end
        end
        TAIL: begin
          if (cnt_done) begin
            en_reg    <= 1'b0;
            sent_reg  <= sent_reg + 8'h01;
            cnt_reg   <= 8'(EN_LOW_CYC - 1);
            state_reg <= GAP;
          end
        end
        GAP: begin
          if (cnt_done) begin
            state_reg <= IDLE;
          end
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end

  assign link.sclk               = sclk_reg;
  assign link.sdata              = sdata_reg;
  assign link.serial_enable_high = en_reg;

endmodule : amp_serial_host

`default_nettype wire

// >>> testbench/amp_serial_asserts.sv
// Concurrent checks on the three-wire link and on the latched settings.
`default_nettype none

module amp_serial_asserts
  import amp_serial_pkg::*;
(
  input wire logic                             aclk,
  input wire logic                             aresetn,
  input wire logic                             sclk,
  input wire logic                             sdata,
  input wire logic                             serial_enable_high,
  input wire logic [amp_serial_pkg::MODE_W-1:0] mode,
  input wire logic [amp_serial_pkg::VOL_W-1:0]  volume,
  input wire logic                             word_latched,
  input wire logic                             transfer_aborted,
  input wire logic                             loudspeaker_output_off
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Link timing and commit checks, all in the local clock domain
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The link clock never moves in the same cycle as the enable.
  clk_en_apart_a: assert property ($changed(sclk) |-> $stable(serial_enable_high))
    else $error("serial clock and enable moved together");
  clk_in_frame_a: assert property ($rose(sclk) |-> !$past(sclk) && $past(serial_enable_high, 4))
    else $error("serial clock rose without enable setup");
  clk_high_time_a: assert property ($rose(sclk) |=> sclk [*8])
    else $error("serial clock high phase too short");
  data_hold_a: assert property ($rose(sclk) |=> $stable(sdata) [*4])
    else $error("serial data moved inside hold time");
  enable_gap_a: assert property ($fell(serial_enable_high) |=> !serial_enable_high [*5])
    else $error("enable low gap too short");
  latch_after_fall_a: assert property (word_latched |-> !$past(serial_enable_high, 5))
    else $error("word latched without enable fall");
  latch_or_abort_a: assert property (!(word_latched && transfer_aborted))
    else $error("frame both latched and aborted");
  settings_commit_a: assert property (($changed(mode) || $changed(volume)) |-> ##[0:1] word_latched)
    else $error("settings changed without a commit");
  abort_keeps_a: assert property (transfer_aborted |-> $stable(mode) && $stable(volume))
    else $error("aborted frame changed settings");
  powerup_off_a: assert property ($rose(aresetn) |-> mode == MODE_RESET && loudspeaker_output_off)
    else $error("device not shut down after reset");

endmodule : amp_serial_asserts

`default_nettype wire

// >>> testbench/amp_serial_mode_volume_port_bench.sv
// Self-checking bench: AXI4-Lite host end driving the serial port end to end.
`default_nettype none

module amp_serial_mode_volume_port_bench;
  import amp_serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Expected shutdown and routing flags, one bit per mode code.
  localparam logic [7:0] SPK_OFF = 8'h55;
  localparam logic [7:0] HP_OFF  = 8'h2b;
  localparam logic [7:0] PH      = 8'ha2;
  localparam logic [7:0] SUM     = 8'h28;
  localparam logic [7:0] HCH     = 8'hd0;
  localparam logic [7:0] HPH     = 8'hc4;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hf;
  logic [2:0]  mode;
  logic [4:0]  volume;
  logic [9:0]  gain;
  logic        spk_off, rhp_off, lhp_off, f_ph, f_sum, f_hch, f_hph, latched, aborted;
  int          n_errors = 0, num_checks = 0, n_lat = 0, n_ab = 0;

  always #2.5 aclk = ~aclk;

  amp_serial_if link ();
  amp_serial_host u_amp_serial_host (.aclk(aclk), .aresetn(aresetn), .link(link.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  amp_serial_device u_amp_serial_device (.aclk(aclk), .aresetn(aresetn), .link(link.device),
    .mode(mode), .volume(volume), .gain_tenth_db(gain), .loudspeaker_output_off(spk_off),
    .right_headphone_output_off(rhp_off), .left_headphone_output_off(lhp_off),
    .spk_phone_6db(f_ph), .spk_gained_sum(f_sum), .hp_gained_channels(f_hch),
    .hp_phone(f_hph), .word_latched(latched), .transfer_aborted(aborted));
  amp_serial_asserts u_amp_serial_asserts (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk),
    .sdata(link.sdata), .serial_enable_high(link.serial_enable_high), .mode(mode),
    .volume(volume), .word_latched(latched), .transfer_aborted(aborted),
    .loudspeaker_output_off(spk_off));

  // Counts commit and abort pulses of the device.
  always @(posedge aclk) begin
    if (latched === 1'b1) n_lat <= n_lat + 1;
    if (aborted === 1'b1) n_ab <= n_ab + 1;
  end

  // ---------------------------------------------------------------------------
  // Compare, report and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic tmo();
    n_errors++;
    $display("wrong value at %0t: no answer in time", $time);
    conclude();
  endtask : tmo

  // Write: offers address and data together, holds bready until the response.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) tmo();
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Sends one frame, checks that a second order is refused when len is over 4, waits for the outcome.
  task automatic frame(input logic [7:0] w, input logic [3:0] len);
    int n;
    int ev;
    logic [1:0] r;
    logic [31:0] d;
    ev = n_lat + n_ab;
    wr(CMD_OFFSET, {20'h0, len, w}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    if (len > 4'h4) begin
      wr(CMD_OFFSET, 32'h0, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
    end
    for (n = 0; n < 4000 && n_lat + n_ab == ev; n++) @(posedge aclk);
    if (n == 4000) tmo();
    for (n = 0; n < 100; n++) begin
      rd(STATUS_OFFSET, d, r);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (n == 100) tmo();
  endtask : frame

  task automatic expect_set(input logic [2:0] m, input logic [4:0] v);
    logic [9:0] g;
    g = 10'(-405 + 15 * int'(v));
    check({29'h0, mode}, {29'h0, m});
    check({27'h0, volume}, {27'h0, v});
    check({22'h0, gain}, {22'h0, g});
    check({29'h0, spk_off, rhp_off, lhp_off}, {29'h0, SPK_OFF[m], HP_OFF[m], HP_OFF[m]});
    check({28'h0, f_ph, f_sum, f_hch, f_hph}, {28'h0, PH[m], SUM[m], HCH[m], HPH[m]});
  endtask : expect_set

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [4:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_set(3'h0, 5'h00);
    for (int i = 0; i < 8; i++) begin
      v = (i == 7) ? 5'h1f : 5'(i * 4);
      frame({v, 3'(i)}, 4'h8);
      expect_set(3'(i), v);
    end
    check(32'(n_lat), 32'd8);
    frame(8'h9e, 4'hf);
    expect_set(3'h6, 5'h13);
    frame(8'h21, 4'h5);
    expect_set(3'h6, 5'h13);
    frame(8'hff, 4'h0);
    expect_set(3'h6, 5'h13);
    check(32'(n_ab), 32'd2);
    frame(8'h21, 4'h8);
    expect_set(3'h1, 5'h04);
    check(32'(n_lat), 32'd10);
    wr(32'h0000_0010, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(32'h0000_0010, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    // A command with its low byte lanes off is refused and starts nothing.
    wstrb <= 4'hc;
    wr(CMD_OFFSET, 32'h0000_0821, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wstrb <= 4'hf;
    rd(STATUS_OFFSET, d, r);
    check({24'h0, d[15:8]}, 32'd12);
    check({31'h0, d[STAT_BUSY_BIT]}, 32'h0);
    conclude();
  end

endmodule : amp_serial_mode_volume_port_bench

`default_nettype wire
